/* include/spi_eeprom_params.svh */
// Constants for the serial EEPROM command, status and protection block
`ifndef SPI_EEPROM_PARAMS_SVH
`define SPI_EEPROM_PARAMS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OPC_SET_WRITE_LATCH 8'h06
`define OPC_CLEAR_WRITE_LATCH 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_ARRAY_READ 8'h03
`define OPC_ARRAY_WRITE 8'h02

// ****************************************************************
// Status byte fields and reset values
// ****************************************************************
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_GUARD_LOW_BIT 2
`define ST_GUARD_HIGH_BIT 3
`define ST_LOCK_BIT 7
`define ST_GUARD_RST 2'h0
`define ST_LOCK_RST 1'h0

// ****************************************************************
// Guarded array ranges, by block guard code
// ****************************************************************
`define GUARD_QUARTER_BASE 16'hC000
`define GUARD_HALF_BASE 16'h8000
`define GUARD_WHOLE_BASE 16'h0000
`define ADDR_WIDTH 16

// ****************************************************************
// Timing
// ****************************************************************
`define CORE_CLK_PERIOD_NS 25
`define SELF_TIMED_CYCLE_TIME_US 5000
`define SELF_TIMED_CYCLE_TICKS \
  ((`SELF_TIMED_CYCLE_TIME_US * 1000) / `CORE_CLK_PERIOD_NS)

`endif

/* include/spi_eeprom_pkg.sv */
// Types for the serial EEPROM command, status and protection block
package spi_eeprom_pkg;

  typedef enum logic [8:0] {
    S_IDLE     = 9'h001,
    S_OPCODE   = 9'h002,
    S_WAIT_CS  = 9'h004,
    S_STAT_OUT = 9'h008,
    S_STAT_IN  = 9'h010,
    S_ADDR     = 9'h020,
    S_ARR_WR   = 9'h040,
    S_ARR_RD   = 9'h080,
    S_IGNORE   = 9'h100
  } state_t;

  typedef enum logic {
    CYC_ARRAY  = 1'b0,
    CYC_STATUS = 1'b1
  } cycle_kind_t;

endpackage

/* rtl/spi_eeprom_command_status_protection.sv */
// Opcode decoder, status register and write guard of a serial EEPROM
`timescale 1ns/100ps
`include "spi_eeprom_params.svh"

module spi_eeprom_command_status_protection
  import spi_eeprom_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = `SELF_TIMED_CYCLE_TICKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic write_protect_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic array_write_start,
  output logic array_read_active,
  output logic [`ADDR_WIDTH-1:0] array_addr,
  output logic write_busy_flag,
  output logic write_enable_latch_flag,
  output logic hard_guard_mode,
  output logic soft_guard_mode,
  output logic [7:0] status_register
);

  localparam int CW = $clog2(CYCLE_TICKS + 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(CYCLE_TICKS - 1);

  if (CYCLE_TICKS < 1) begin : g_bad_ticks
    $error("CYCLE_TICKS must be at least one");
  end

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  // Chip select chain resets low so a select held low through reset is
  // not taken as a falling edge: a fresh fall is required after reset.
  logic sck_m_q, sck_s_q, sck_p_q;
  logic cs_m_q, cs_s_q, cs_p_q;
  logic mosi_m_q, mosi_s_q;
  logic wp_m_q, wp_s_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      cs_m_q <= 1'b0;
      cs_s_q <= 1'b0;
      cs_p_q <= 1'b0;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      sck_m_q <= spi_sck;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      cs_m_q <= spi_cs_n;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      mosi_m_q <= spi_mosi;
      mosi_s_q <= mosi_m_q;
      wp_m_q <= write_protect_n;
      wp_s_q <= wp_m_q;
    end
  end

  wire sck_rise = sck_s_q & ~sck_p_q;
  wire sck_fall = ~sck_s_q & sck_p_q;
  wire cs_fall = ~cs_s_q & cs_p_q;
  wire cs_rise = cs_s_q & ~cs_p_q;

  // ****************************************************************
  // State and shift registers
  // ****************************************************************
  state_t state_q, state_d;
  logic [2:0] bit_cnt_q;
  logic [7:0] in_sr_q;
  logic [7:0] cmd_q;
  logic addr_hi_q;
  logic got_byte_q;
  logic [`ADDR_WIDTH-1:0] addr_q;
  logic [2:0] out_cnt_q;
  logic [6:0] out_sr_q;
  logic miso_q;
  logic wr_start_q;

  logic busy_q, wel_q, lock_q, lock_new_q;
  logic [1:0] guard_q, guard_new_q;
  cycle_kind_t kind_q;
  logic [CW-1:0] cyc_cnt_q;

  wire byte_end = sck_rise && (bit_cnt_q == 3'h7);
  wire [7:0] opcode_full = {in_sr_q[6:0], mosi_s_q};
  wire in_opcode = (state_q == S_OPCODE);
  wire in_wait = (state_q == S_WAIT_CS);

  // Hard guard is a live AND of lock and pin, so the order in which they
  // arrive does not matter; only the pin, or a status write accepted before the pin fell, can end it.
  wire hard_guard = lock_q & ~wp_s_q;

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  wire opc_set = (opcode_full == `OPC_SET_WRITE_LATCH);
  wire opc_clr = (opcode_full == `OPC_CLEAR_WRITE_LATCH);
  wire opc_srd = (opcode_full == `OPC_STATUS_READ);
  wire opc_swr = (opcode_full == `OPC_STATUS_WRITE);
  wire opc_ard = (opcode_full == `OPC_ARRAY_READ);
  wire opc_awr = (opcode_full == `OPC_ARRAY_WRITE);
  wire opc_bad = ~(opc_set | opc_clr | opc_srd | opc_swr | opc_ard | opc_awr);

  // ****************************************************************
  // Guarded range check
  // ****************************************************************
  logic addr_guarded;
  always_comb begin
    unique case (guard_q)
      2'h0: addr_guarded = 1'b0;
      2'h1: addr_guarded = (addr_q >= `GUARD_QUARTER_BASE);
      2'h2: addr_guarded = (addr_q >= `GUARD_HALF_BASE);
      2'h3: addr_guarded = (addr_q >= `GUARD_WHOLE_BASE);
    endcase
  end

  // ****************************************************************
  // Execution at chip select rise
  // ****************************************************************
  wire exec_set = cs_rise && in_wait && (cmd_q == `OPC_SET_WRITE_LATCH);
  wire exec_clr = cs_rise && in_wait && (cmd_q == `OPC_CLEAR_WRITE_LATCH);
  wire swr_framed = cs_rise && in_wait && (cmd_q == `OPC_STATUS_WRITE);
  wire exec_swr = swr_framed && wel_q && !busy_q && !hard_guard;
  // Array write must end on a byte boundary with at least one data byte.
  wire awr_framed = cs_rise && (state_q == S_ARR_WR) &&
                    (bit_cnt_q == 3'h0) && got_byte_q;
  wire exec_awr = awr_framed && wel_q && !busy_q && !addr_guarded;
  wire cyc_done = busy_q && (cyc_cnt_q == LAST_TICK);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    if (cs_s_q) begin
      state_d = S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (cs_fall) begin
            state_d = S_OPCODE;
          end
        end
        S_OPCODE: begin
          if (byte_end) begin
            if (opc_set || opc_clr) begin
              state_d = S_WAIT_CS;
            end else if (opc_srd) begin
              state_d = S_STAT_OUT;
            end else if (opc_swr) begin
              state_d = S_STAT_IN;
            end else if (opc_awr || (opc_ard && !busy_q)) begin
              state_d = S_ADDR;
            end else begin
              state_d = S_IGNORE;
            end
          end
        end
        S_WAIT_CS: begin
          // A clock rise past the last bit voids the instruction.
          if (sck_rise) begin
            state_d = S_IGNORE;
          end
        end
        S_STAT_IN: begin
          if (byte_end) begin
            state_d = S_WAIT_CS;
          end
        end
        S_ADDR: begin
          if (byte_end && addr_hi_q) begin
            state_d = (cmd_q == `OPC_ARRAY_READ) ? S_ARR_RD : S_ARR_WR;
          end
        end
        S_STAT_OUT, S_ARR_WR, S_ARR_RD, S_IGNORE: begin
          state_d = state_q;
        end
        default: begin
          state_d = S_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 3'h0;
      in_sr_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_hi_q <= 1'b0;
      got_byte_q <= 1'b0;
      addr_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == S_IDLE) begin
        bit_cnt_q <= 3'h0;
        addr_hi_q <= 1'b0;
        got_byte_q <= 1'b0;
      end else if (sck_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        in_sr_q <= opcode_full;
      end
      if (in_opcode && byte_end) begin
        cmd_q <= opcode_full;
      end
      if ((state_q == S_ADDR) && sck_rise) begin
        addr_q <= {addr_q[`ADDR_WIDTH-2:0], mosi_s_q};
      end
      if ((state_q == S_ADDR) && byte_end) begin
        addr_hi_q <= 1'b1;
      end
      if ((state_q == S_ARR_WR) && byte_end) begin
        got_byte_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status register and self-timed cycle
  // ****************************************************************
  // Guard and lock reset to their delivery values: reset here stands in
  // for first power-up, not for a later power cycle of the real cells.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      lock_q <= `ST_LOCK_RST;
      guard_q <= `ST_GUARD_RST;
      lock_new_q <= `ST_LOCK_RST;
      guard_new_q <= `ST_GUARD_RST;
      kind_q <= CYC_ARRAY;
      cyc_cnt_q <= '0;
      wr_start_q <= 1'b0;
    end else begin
      wr_start_q <= exec_awr;
      if (exec_swr || exec_awr) begin
        busy_q <= 1'b1;
        cyc_cnt_q <= '0;
        kind_q <= exec_swr ? CYC_STATUS : CYC_ARRAY;
      end else if (cyc_done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cyc_cnt_q <= cyc_cnt_q + CW'(1);
      end
      if (exec_swr) begin
        lock_new_q <= in_sr_q[`ST_LOCK_BIT];
        guard_new_q <= in_sr_q[`ST_GUARD_HIGH_BIT:`ST_GUARD_LOW_BIT];
      end
      if (cyc_done && (kind_q == CYC_STATUS)) begin
        lock_q <= lock_new_q;
        guard_q <= guard_new_q;
      end
      // A set arriving with a clearing event wins.
      if (exec_set) begin
        wel_q <= 1'b1;
      end else if (exec_clr || cyc_done) begin
        wel_q <= 1'b0;
      end
    end
  end

  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY_BIT] = busy_q;
    status_byte[`ST_WEL_BIT] = wel_q;
    status_byte[`ST_GUARD_HIGH_BIT:`ST_GUARD_LOW_BIT] = guard_q;
    status_byte[`ST_LOCK_BIT] = lock_q;
  end

  // ****************************************************************
  // Status read-out
  // ****************************************************************
  // Each new byte takes a fresh snapshot so polling sees busy drop.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_cnt_q <= 3'h0;
      out_sr_q <= 7'h00;
      miso_q <= 1'b0;
    end else if (state_q != S_STAT_OUT) begin
      out_cnt_q <= 3'h0;
    end else if (sck_fall) begin
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        {miso_q, out_sr_q} <= status_byte;
      end else begin
        {miso_q, out_sr_q} <= {out_sr_q, 1'b0};
      end
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = (state_q == S_STAT_OUT);
  assign array_write_start = wr_start_q;
  assign array_read_active = (state_q == S_ARR_RD);
  assign array_addr = addr_q;
  assign write_busy_flag = busy_q;
  assign write_enable_latch_flag = wel_q;
  assign hard_guard_mode = hard_guard;
  assign soft_guard_mode = ~hard_guard;
  assign status_register = status_byte;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic [CW-1:0] busy_run_q;
  always_ff @(posedge core_clk) begin
    if (srst || !busy_q) begin
      busy_run_q <= '0;
    end else begin
      busy_run_q <= busy_run_q + CW'(1);
    end
  end

  chk_set_latch_exec: assert property (
    exec_set |=> wel_q
  ) else $error("set latch not taken at select rise");

  chk_clear_latch_exec: assert property (
    exec_clr && !exec_set |=> !wel_q
  ) else $error("clear latch not taken at select rise");

  chk_busy_length: assert property (
    $fell(busy_q) |-> $past(busy_run_q) == LAST_TICK
  ) else $error("busy length differs from cycle time");

  chk_latch_after_cycle: assert property (
    $fell(busy_q) && !$past(exec_set) |-> !wel_q
  ) else $error("latch still set after write cycle");

  chk_guard_frozen: assert property (
    busy_q && $past(busy_q) && !$past(cyc_done) |->
      $stable(lock_q) && $stable(guard_q)
  ) else $error("guard bits changed during write cycle");

  chk_status_accept: assert property (
    $rose(busy_q) && kind_q == CYC_STATUS |->
      $past(wel_q) && !$past(lock_q && !wp_s_q)
  ) else $error("status write accepted while refused");

  chk_array_guard: assert property (
    exec_awr |-> ##1 array_write_start ##0 busy_q ##0
      !((guard_q == 2'h3) || (guard_q == 2'h2 && addr_q[15]) ||
        (guard_q == 2'h1 && addr_q[15:14] == 2'h3))
  ) else $error("guarded array write started");

  chk_bad_opcode: assert property (
    in_opcode && byte_end && opc_bad && !cs_s_q |=>
      state_q == S_IGNORE [*2]
  ) else $error("unknown opcode not ignored");

  chk_status_drive: assert property (
    in_opcode && byte_end && opc_srd && !cs_s_q |=> spi_miso_oe
  ) else $error("status read does not drive output");

  cov_status_write: cover property (
    exec_swr ##1 busy_q && kind_q == CYC_STATUS
  );
  cov_array_write: cover property (exec_awr);
  cov_hard_reject: cover property (swr_framed && wel_q && hard_guard);
  cov_status_repeat: cover property (
    state_q == S_STAT_OUT && sck_fall && out_cnt_q == 3'h0 &&
      $past(out_cnt_q) == 3'h0 ##[1:200] sck_fall && out_cnt_q == 3'h0
  );

endmodule

/* bench/spi_master_model.sv */
// Mode 0 serial bus master model that talks to the EEPROM block
`timescale 1ns/100ps
module spi_master_model #(
  parameter real HALF_NS = 100.0
) (
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  logic sel;
  logic mosi_bit;
  logic idle_pat;

  // ****************************************************************
  // Line levels
  // ****************************************************************
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    sel = 1'b0;
    mosi_bit = 1'b0;
    idle_pat = 1'b0;
  end

  // Released data line toggles so a stale bit is never mistaken for data
  always #(HALF_NS * 0.35) idle_pat = ~idle_pat;
  assign spi_mosi = sel ? mosi_bit : idle_pat;

  // Odd offset keeps the link edges away from the core clock edges
  task automatic start_frame();
    #37;
    spi_cs_n = 1'b0;
    sel = 1'b1;
    #(HALF_NS);
  endtask

  // Device launches late after a fall, so read just before the next fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_bit = tx[i];
      #(HALF_NS);
      spi_sck = 1'b1;
      #(HALF_NS);
      rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      spi_sck = 1'b0;
    end
  endtask

  // One clock rise too many voids the instruction in progress
  task automatic extra_rise();
    #(HALF_NS);
    spi_sck = 1'b1;
    #(HALF_NS);
    spi_sck = 1'b0;
  endtask

  task automatic end_frame();
    #(HALF_NS / 2);
    spi_cs_n = 1'b1;
    sel = 1'b0;
    #(HALF_NS * 2);
  endtask
endmodule

/* bench/spi_eeprom_command_status_protection_bench.sv */
// Self-checking bench for the EEPROM command, status and guard block
`timescale 1ns/100ps
module spi_eeprom_command_status_protection_bench;
  localparam int TICKS = 200;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic write_protect_n = 1'b1;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic array_write_start, array_read_active, write_busy_flag;
  logic write_enable_latch_flag, hard_guard_mode, soft_guard_mode;
  logic [15:0] array_addr;
  logic [7:0] status_register;
  logic [7:0] rx;
  logic [7:0] st;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int starts = 0;

  always #12.5 core_clk = ~core_clk;

  spi_eeprom_command_status_protection #(.CYCLE_TICKS(TICKS)) DUT (
    .core_clk(core_clk),
    .srst(srst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .write_protect_n(write_protect_n),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .array_write_start(array_write_start),
    .array_read_active(array_read_active),
    .array_addr(array_addr),
    .write_busy_flag(write_busy_flag),
    .write_enable_latch_flag(write_enable_latch_flag),
    .hard_guard_mode(hard_guard_mode),
    .soft_guard_mode(soft_guard_mode),
    .status_register(status_register)
  );

  spi_master_model master (
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi)
  );

  always @(posedge core_clk) begin
    if (array_write_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // Whole run is near 12000 cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    master.start_frame();
    master.xfer(op, rx);
    master.end_frame();
  endtask

  task automatic read_status(output logic [7:0] s);
    master.start_frame();
    master.xfer(8'h05, rx);
    master.xfer(8'h00, s);
    master.end_frame();
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 400 && write_busy_flag !== 1'b0; i++) begin
      @(negedge core_clk);
    end
  endtask

  task automatic write_status(input logic [7:0] d, input bit set_write_latch_cmd,
                              input bit extra);
    if (set_write_latch_cmd) cmd(8'h06);
    master.start_frame();
    master.xfer(8'h01, rx);
    master.xfer(d, rx);
    if (extra) master.extra_rise();
    master.end_frame();
  endtask

  task automatic array_write(input logic [15:0] a, input bit set_write_latch_cmd);
    if (set_write_latch_cmd) cmd(8'h06);
    master.start_frame();
    master.xfer(8'h02, rx);
    master.xfer(a[15:8], rx);
    master.xfer(a[7:0], rx);
    master.xfer(8'hA5, rx);
    master.end_frame();
  endtask

  task automatic set_pin(input logic lvl);
    @(negedge core_clk);
    write_protect_n = lvl;
    repeat (6) @(negedge core_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_latch();
    check(status_register, 8'h00);
    master.start_frame();
    master.xfer(8'h06, rx);
    #400;
    check(write_enable_latch_flag, 1'b0);
    master.end_frame();
    check(write_enable_latch_flag, 1'b1);
    master.start_frame();
    master.xfer(8'h05, rx);
    master.xfer(8'h00, st);
    check(st, 8'h02);
    master.xfer(8'h00, st);
    check(st, 8'h02);
    master.end_frame();
    cmd(8'h04);
    check(write_enable_latch_flag, 1'b0);
    master.start_frame();
    master.xfer(8'hFF, rx);
    master.xfer(8'h06, rx);
    master.end_frame();
    check(write_enable_latch_flag, 1'b0);
  endtask

  task automatic t_status();
    write_status(8'h8C, 1'b0, 1'b0);
    check(write_busy_flag, 1'b0);
    write_status(8'h8C, 1'b1, 1'b1);
    check(status_register & 8'hFD, 8'h00);
    write_status(8'hFF, 1'b1, 1'b0);
    check(write_busy_flag, 1'b1);
    read_status(st);
    check(st, 8'h03);
    wait_idle();
    check(status_register, 8'h8C);
    check({hard_guard_mode, soft_guard_mode}, 2'b01);
    set_pin(1'b0);
    check({hard_guard_mode, soft_guard_mode}, 2'b10);
    write_status(8'h00, 1'b1, 1'b0);
    check(status_register, 8'h8E);
    check(hard_guard_mode, 1'b1);
    set_pin(1'b1);
    check(hard_guard_mode, 1'b0);
    write_status(8'h00, 1'b1, 1'b0);
    wait_idle();
    check(status_register, 8'h00);
    set_pin(1'b0);
    write_status(8'h80, 1'b1, 1'b0);
    wait_idle();
    check(status_register, 8'h80);
    check(hard_guard_mode, 1'b1);
    set_pin(1'b1);
  endtask

  task automatic t_guard();
    logic [15:0] addrs [4] = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000};
    int n;
    bit ok;
    for (int c = 0; c < 4; c++) begin
      write_status({4'h0, c[1:0], 2'b00}, 1'b1, 1'b0);
      wait_idle();
      for (int i = 0; i < 4; i++) begin
        n = starts;
        ok = !(c == 3 || (c == 2 && addrs[i] >= 16'h8000) ||
               (c == 1 && addrs[i] >= 16'hC000));
        array_write(addrs[i], 1'b1);
        check(starts - n, ok);
        check(write_busy_flag, ok);
        if (ok) check(array_addr, addrs[i]);
        wait_idle();
        check(write_enable_latch_flag, !ok);
      end
    end
    write_status(8'h00, 1'b1, 1'b0);
    wait_idle();
    n = starts;
    array_write(16'h0000, 1'b0);
    check(starts - n, 0);
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    repeat (8) @(negedge core_clk);
    t_latch();
    t_status();
    t_guard();
    report_and_stop();
  end
endmodule
